// [rtl/prg_if.sv]
// Interface joining the top of the block to its reset bank and port gate
`timescale 1ns/100ps
interface prg_if;
  logic [2:0] srst_wr;
  logic [31:0] wr_data;
  logic [2:0][31:0] cap_mask;
  logic [2:0][31:0] srst_val;
  logic [4:0] ds_gate;
  logic [4:0] run_gate;
  logic deep_active;
  logic acc_valid;
  logic [2:0] acc_port;
  logic [4:0] clk_en;
  logic acc_fault;
  logic acc_ok;

  modport top (
    output srst_wr, wr_data, cap_mask, ds_gate, run_gate, deep_active, acc_valid, acc_port,
    input srst_val, clk_en, acc_fault, acc_ok
  );
  modport bank (
    input srst_wr, wr_data, cap_mask,
    output srst_val
  );
  modport gate (
    input ds_gate, run_gate, deep_active, acc_valid, acc_port,
    output clk_en, acc_fault, acc_ok
  );
endinterface

// [rtl/prg_pkg.sv]
// Package of offsets, field layouts and reset values for the reset and gating block
package prg_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] PRG_OFF_SRST0 = 12'h040;
  localparam logic [11:0] PRG_OFF_SRST1 = 12'h044;
  localparam logic [11:0] PRG_OFF_SRST2 = 12'h048;
  localparam logic [11:0] PRG_OFF_DSGATE = 12'h128;
  localparam logic [11:0] PRG_OFF_IRQ_STAT = 12'h150;
  localparam logic [11:0] PRG_OFF_IRQ_MASK = 12'h154;
  localparam logic [11:0] PRG_OFF_STATE = 12'h158;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PRG_BIT_ADC0 = 16;
  localparam int PRG_BIT_WDOG = 3;
  localparam int PRG_BIT_TMR0 = 16;
  localparam int PRG_BIT_TWI0 = 12;
  localparam int PRG_BIT_SSER0 = 4;
  localparam int PRG_BIT_SPORT0 = 0;
  localparam int PRG_BIT_PORT_A = 0;
  localparam int PRG_NUM_PORTS = 5;
  localparam int PRG_NUM_SRST = 3;
  localparam int PRG_EV_FAULT = 0;
  localparam int PRG_EV_RST_SET = 1;
  localparam int PRG_EV_RST_REL = 2;
  localparam int PRG_EV_DEEP_IN = 3;
  localparam int PRG_EV_DEEP_OUT = 4;
  localparam int PRG_NUM_EV = 5;
  localparam int PRG_ST_DEEP = 8;

  // ****************************************
  // Writable bit masks and reset values
  // ****************************************
  localparam logic [31:0] PRG_SRST0_WMASK = 32'h0001_0008;
  localparam logic [31:0] PRG_SRST1_WMASK = 32'h0007_1013;
  localparam logic [31:0] PRG_SRST2_WMASK = 32'h0000_001f;
  localparam logic [31:0] PRG_SRST_RESET = 32'h0000_0000;
  localparam logic [4:0] PRG_DSGATE_RESET = 5'h00;
  localparam logic [4:0] PRG_IRQ_RESET = 5'h00;

  typedef enum logic [0:0] {
    PRG_PM_RUN = 1'b0,
    PRG_PM_DEEP = 1'b1
  } prg_pm_e;
endpackage

// [rtl/prg_port_gate.sv]
// Per-port clock enables and the fault check for accesses to gated ports
`timescale 1ns/100ps
module prg_port_gate
  import prg_pkg::*;
(
  prg_if.gate bus
);
  // ****************************************
  // Clock enable per port
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < PRG_NUM_PORTS; gi++) begin : g_port
      // Deep-sleep setting applies only in deep sleep with auto gating chosen
      assign bus.clk_en[gi] = bus.deep_active ? bus.ds_gate[gi] : bus.run_gate[gi];
    end
  endgenerate

  // ****************************************
  // Access check
  // ****************************************
  wire port_known;
  wire port_clocked;
  assign port_known = bus.acc_port < 3'(PRG_NUM_PORTS);
  assign port_clocked = port_known && bus.clk_en[bus.acc_port];
  // Unknown port index faults too, never silently completes
  assign bus.acc_fault = bus.acc_valid && !port_clocked;
  assign bus.acc_ok = bus.acc_valid && port_clocked;
endmodule

// [rtl/prg_srst_bank.sv]
// Three software reset control registers with capability-masked writes
`timescale 1ns/100ps
module prg_srst_bank
  import prg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  prg_if.bank bus
);
  // ****************************************
  // Register bank
  // ****************************************
  localparam logic [2:0][31:0] WMASK = {PRG_SRST2_WMASK, PRG_SRST1_WMASK, PRG_SRST0_WMASK};

  genvar gi;
  generate
    for (gi = 0; gi < PRG_NUM_SRST; gi++) begin : g_reg
      logic [31:0] val_q;
      logic [31:0] val_d;
      // Absent units and reserved bits can never be set
      assign val_d = bus.srst_wr[gi] ? (bus.wr_data & bus.cap_mask[gi] & WMASK[gi]) : val_q;
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          val_q <= PRG_SRST_RESET;
        end else begin
          val_q <= val_d;
        end
      end
      assign bus.srst_val[gi] = val_q;
    end
  endgenerate
endmodule

// [rtl/prg_top.sv]
// Top of the peripheral software reset and port clock gating block
//
// Notes on behaviour
// - Each gating bit 4..0 clocks port E..A when set and stops and disables it when clear.
// - An access to a port whose clock is off is answered with a bus fault.
// - Writes to each soft reset register are masked by its capability mask.
// - Bit 16 of soft reset register 0 resets analog converter zero.
// - Bit 3 of soft reset register 0 resets the watchdog.
// - Bits 18, 17, 16 of soft reset register 1 reset timers two, one and zero.
// - Bit 12 of soft reset register 1 resets two-wire unit zero.
// - Bit 4 of soft reset register 1 resets synchronous serial unit zero.
// - Bits 1 and 0 of soft reset register 1 reset serial ports one and zero.
// - Bits 4..0 of soft reset register 2 reset ports E, D, C, B and A.
// - Reserved bits are read-only zero and software keeps them across updates.
// - All soft reset registers leave system reset at zero.
// - Deep-sleep gating rules the port clocks only in deep sleep with auto gating on.
`timescale 1ns/100ps
module prg_top
  import prg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] capability_mask_a,
  input wire logic [31:0] capability_mask_b,
  input wire logic [31:0] capability_mask_d,
  input wire logic deep_sleep,
  input wire logic auto_clock_gating,
  input wire logic [4:0] run_port_gating,
  input wire logic port_acc_valid,
  input wire logic [2:0] port_acc_sel,
  output logic port_acc_ok,
  output logic port_acc_fault,
  output logic [4:0] port_clk_en,
  output logic adc_zero_rst,
  output logic watchdog_reset_bit,
  output logic timer_zero_reset_bit,
  output logic timer_one_reset_bit,
  output logic timer_two_reset_bit,
  output logic two_wire_unit_reset_bit,
  output logic sync_serial_unit_reset_bit,
  output logic serial_port_zero_reset_bit,
  output logic serial_port_one_reset_bit,
  output logic port_a_bit,
  output logic port_b_bit,
  output logic port_c_bit,
  output logic port_d_bit,
  output logic port_e_bit,
  output logic irq
);
  // ****************************************
  // Internal signals
  // ****************************************
  prg_if link ();

  logic [4:0] ds_gate_q;
  logic [4:0] ds_gate_d;
  logic [4:0] irq_stat_q;
  logic [4:0] irq_stat_d;
  logic [4:0] irq_mask_q;
  logic [4:0] irq_mask_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic any_rst_q;
  prg_pm_e pm_q;
  prg_pm_e pm_d;

  wire sel_srst0;
  wire sel_srst1;
  wire sel_srst2;
  wire sel_dsgate;
  wire sel_stat;
  wire sel_mask;
  wire sel_state;
  wire wr_dsgate;
  wire wr_stat;
  wire wr_mask;
  wire [31:0] srst0;
  wire [31:0] srst1;
  wire [31:0] srst2;
  wire any_rst;
  wire deep_active;
  wire [4:0] ev_set;
  wire [31:0] rd_mux;
  wire [31:0] state_word;

  // ****************************************
  // Address decode
  // ****************************************
  assign sel_srst0 = reg_addr == PRG_OFF_SRST0;
  assign sel_srst1 = reg_addr == PRG_OFF_SRST1;
  assign sel_srst2 = reg_addr == PRG_OFF_SRST2;
  assign sel_dsgate = reg_addr == PRG_OFF_DSGATE;
  assign sel_stat = reg_addr == PRG_OFF_IRQ_STAT;
  assign sel_mask = reg_addr == PRG_OFF_IRQ_MASK;
  assign sel_state = reg_addr == PRG_OFF_STATE;

  assign wr_dsgate = reg_wr && sel_dsgate;
  assign wr_stat = reg_wr && sel_stat;
  assign wr_mask = reg_wr && sel_mask;

  // ****************************************
  // Soft reset bank
  // ****************************************
  assign link.srst_wr = {reg_wr && sel_srst2, reg_wr && sel_srst1, reg_wr && sel_srst0};
  assign link.wr_data = reg_wdata;
  assign link.cap_mask = {capability_mask_d, capability_mask_b, capability_mask_a};

  prg_srst_bank u_bank (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .bus(link)
  );

  assign srst0 = link.srst_val[0];
  assign srst1 = link.srst_val[1];
  assign srst2 = link.srst_val[2];

  // ****************************************
  // Unit reset outputs
  // ****************************************
  // A unit stays in reset for as long as its bit is set
  assign adc_zero_rst = srst0[PRG_BIT_ADC0];
  assign watchdog_reset_bit = srst0[PRG_BIT_WDOG];
  assign timer_zero_reset_bit = srst1[PRG_BIT_TMR0];
  assign timer_one_reset_bit = srst1[PRG_BIT_TMR0 + 1];
  assign timer_two_reset_bit = srst1[PRG_BIT_TMR0 + 2];
  assign two_wire_unit_reset_bit = srst1[PRG_BIT_TWI0];
  assign sync_serial_unit_reset_bit = srst1[PRG_BIT_SSER0];
  assign serial_port_zero_reset_bit = srst1[PRG_BIT_SPORT0];
  assign serial_port_one_reset_bit = srst1[PRG_BIT_SPORT0 + 1];
  assign port_a_bit = srst2[PRG_BIT_PORT_A];
  assign port_b_bit = srst2[PRG_BIT_PORT_A + 1];
  assign port_c_bit = srst2[PRG_BIT_PORT_A + 2];
  assign port_d_bit = srst2[PRG_BIT_PORT_A + 3];
  assign port_e_bit = srst2[PRG_BIT_PORT_A + 4];

  assign any_rst = |{srst0, srst1, srst2};

  // ****************************************
  // Deep-sleep gating register
  // ****************************************
  assign ds_gate_d = wr_dsgate ? reg_wdata[4:0] : ds_gate_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ds_gate_q <= PRG_DSGATE_RESET;
    end else begin
      ds_gate_q <= ds_gate_d;
    end
  end

  // ****************************************
  // Power mode tracking
  // ****************************************
  // Deep gating only when the clock setup hands sleep gating to hardware
  assign deep_active = deep_sleep && auto_clock_gating;

  always_comb begin
    pm_d = pm_q;
    case (pm_q)
      PRG_PM_RUN: begin
        if (deep_active) begin
          pm_d = PRG_PM_DEEP;
        end
      end
      PRG_PM_DEEP: begin
        if (!deep_active) begin
          pm_d = PRG_PM_RUN;
        end
      end
      default: begin
        pm_d = PRG_PM_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pm_q <= PRG_PM_RUN;
    end else begin
      pm_q <= pm_d;
    end
  end

  // ****************************************
  // Port clock gating
  // ****************************************
  assign link.ds_gate = ds_gate_q;
  assign link.run_gate = run_port_gating;
  assign link.deep_active = deep_active;
  assign link.acc_valid = port_acc_valid;
  assign link.acc_port = port_acc_sel;

  prg_port_gate u_gate (
    .bus(link)
  );

  assign port_clk_en = link.clk_en;
  assign port_acc_fault = link.acc_fault;
  assign port_acc_ok = link.acc_ok;

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  assign ev_set[PRG_EV_FAULT] = link.acc_fault;
  assign ev_set[PRG_EV_RST_SET] = any_rst && !any_rst_q;
  assign ev_set[PRG_EV_RST_REL] = !any_rst && any_rst_q;
  assign ev_set[PRG_EV_DEEP_IN] = pm_q == PRG_PM_RUN && pm_d == PRG_PM_DEEP;
  assign ev_set[PRG_EV_DEEP_OUT] = pm_q == PRG_PM_DEEP && pm_d == PRG_PM_RUN;

  // A new event beats a clear in the same cycle
  assign irq_stat_d = ev_set | (irq_stat_q & ~(wr_stat ? reg_wdata[4:0] : 5'h00));
  assign irq_mask_d = wr_mask ? reg_wdata[4:0] : irq_mask_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      irq_stat_q <= PRG_IRQ_RESET;
      irq_mask_q <= PRG_IRQ_RESET;
      any_rst_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      any_rst_q <= any_rst;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ****************************************
  // Read path
  // ****************************************
  assign state_word = {23'h000000, pm_q == PRG_PM_DEEP, 3'h0, link.clk_en};

  // Unmapped offsets read zero; reserved bits are held zero in storage
  assign rd_mux = sel_srst0 ? srst0 :
                  sel_srst1 ? srst1 :
                  sel_srst2 ? srst2 :
                  sel_dsgate ? {27'h0000000, ds_gate_q} :
                  sel_stat ? {27'h0000000, irq_stat_q} :
                  sel_mask ? {27'h0000000, irq_mask_q} :
                  sel_state ? state_word :
                  32'h0000_0000;

  // Data shows only in the cycle after the strobe
  assign rdata_d = reg_rd ? rd_mux : 32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
endmodule

// [tb/prg_props.sv]
// Checker of port behaviour for the reset and gating block
`timescale 1ns/100ps
module prg_props
  import prg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] capability_mask_a,
  input wire logic [31:0] capability_mask_b,
  input wire logic [31:0] capability_mask_d,
  input wire logic deep_sleep,
  input wire logic auto_clock_gating,
  input wire logic [4:0] run_port_gating,
  input wire logic port_acc_valid,
  input wire logic [2:0] port_acc_sel,
  input wire logic port_acc_ok,
  input wire logic port_acc_fault,
  input wire logic [4:0] port_clk_en,
  input wire logic adc_zero_rst,
  input wire logic watchdog_reset_bit,
  input wire logic timer_zero_reset_bit,
  input wire logic timer_one_reset_bit,
  input wire logic timer_two_reset_bit,
  input wire logic two_wire_unit_reset_bit,
  input wire logic sync_serial_unit_reset_bit,
  input wire logic serial_port_zero_reset_bit,
  input wire logic serial_port_one_reset_bit,
  input wire logic port_a_bit,
  input wire logic port_b_bit,
  input wire logic port_c_bit,
  input wire logic port_d_bit,
  input wire logic port_e_bit,
  input wire logic irq
);
  // ****************************************
  // Register images rebuilt from unit outputs
  // ****************************************
  logic [31:0] v0;
  logic [31:0] v1;
  logic [31:0] v2;
  assign v0 = {15'h0, adc_zero_rst, 12'h0, watchdog_reset_bit, 3'h0};
  assign v1 = {13'h0, timer_two_reset_bit, timer_one_reset_bit, timer_zero_reset_bit, 3'h0,
    two_wire_unit_reset_bit, 7'h0, sync_serial_unit_reset_bit, 2'h0,
    serial_port_one_reset_bit, serial_port_zero_reset_bit};
  assign v2 = {27'h0, port_e_bit, port_d_bit, port_c_bit, port_b_bit, port_a_bit};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  AST_RST_ZERO: assert property ($rose(rst_b) |-> {v0, v1, v2} == 96'h0 && !irq)
    else $error("units not clear after reset");
  AST_HOLD: assert property (!reg_wr |=> $stable({v0, v1, v2}))
    else $error("unit reset changed without a write");
  AST_SRST0_WR: assert property (reg_wr && reg_addr == PRG_OFF_SRST0 |=>
    v0 == ($past(reg_wdata) & $past(capability_mask_a) & PRG_SRST0_WMASK))
    else $error("soft reset 0 write wrong");
  AST_SRST1_WR: assert property (reg_wr && reg_addr == PRG_OFF_SRST1 |=>
    v1 == ($past(reg_wdata) & $past(capability_mask_b) & PRG_SRST1_WMASK))
    else $error("soft reset 1 write wrong");
  AST_SRST2_WR: assert property (reg_wr && reg_addr == PRG_OFF_SRST2 |=>
    v2 == ($past(reg_wdata) & $past(capability_mask_d) & PRG_SRST2_WMASK))
    else $error("soft reset 2 write wrong");
  AST_RD_SRST1: assert property (reg_rd && reg_addr == PRG_OFF_SRST1 |=> reg_rdata == v1)
    else $error("soft reset 1 read wrong");
  AST_FAULT: assert property (port_acc_valid && (port_acc_sel > 3'h4 ||
    !port_clk_en[port_acc_sel]) |-> port_acc_fault && !port_acc_ok)
    else $error("no fault on gated port");
  AST_OK: assert property (port_acc_valid && port_acc_sel <= 3'h4 &&
    port_clk_en[port_acc_sel] |-> port_acc_ok && !port_acc_fault)
    else $error("clocked port refused");
  AST_IDLE: assert property (!port_acc_valid |-> !port_acc_ok && !port_acc_fault)
    else $error("port answer without access");
  AST_RUN_GATE: assert property (!(deep_sleep && auto_clock_gating) |->
    port_clk_en == run_port_gating)
    else $error("run gating not followed");
endmodule
bind prg_top prg_props u_props (.*);

// [tb/tb_top.sv]
// Testbench for the reset and gating block
`timescale 1ns/100ps
module tb_top;
  import prg_pkg::*;
  logic clk_sys, rst_b, reg_wr, reg_rd, deep_sleep, auto_clock_gating, port_acc_valid;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, capability_mask_a, capability_mask_b, capability_mask_d;
  logic [4:0] run_port_gating, port_clk_en;
  logic [2:0] port_acc_sel;
  logic port_acc_ok, port_acc_fault, adc_zero_rst, watchdog_reset_bit, irq;
  logic timer_zero_reset_bit, timer_one_reset_bit, timer_two_reset_bit;
  logic two_wire_unit_reset_bit, sync_serial_unit_reset_bit;
  logic serial_port_zero_reset_bit, serial_port_one_reset_bit;
  logic port_a_bit, port_b_bit, port_c_bit, port_d_bit, port_e_bit;
  logic [31:0] wm [3];
  int miscompares, n_compared;

  prg_top uut (.*);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic acc(input logic [2:0] s, input logic [1:0] e);
    @(posedge clk_sys);
    port_acc_valid <= 1'b1;
    port_acc_sel <= s;
    #1;
    chk({port_acc_ok, port_acc_fault}, e);
    @(posedge clk_sys);
    port_acc_valid <= 1'b0;
    #1;
  endtask
  task automatic print_verdict();
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    print_verdict();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {rst_b, reg_wr, reg_rd, deep_sleep, auto_clock_gating, port_acc_valid} = 6'h0;
    {reg_addr, reg_wdata, port_acc_sel, run_port_gating} = '0;
    {capability_mask_a, capability_mask_b, capability_mask_d} = {96{1'b1}};
    wm = '{PRG_SRST0_WMASK, PRG_SRST1_WMASK, PRG_SRST2_WMASK};
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rdc(PRG_OFF_SRST0 + 12'(4 * i), 32'h0);
      wr(PRG_OFF_SRST0 + 12'(4 * i), 32'hffff_ffff);
      rdc(PRG_OFF_SRST0 + 12'(4 * i), wm[i]);
    end
    chk({adc_zero_rst, watchdog_reset_bit}, 2'h3);
    chk({timer_two_reset_bit, timer_one_reset_bit, timer_zero_reset_bit}, 3'h7);
    chk({two_wire_unit_reset_bit, sync_serial_unit_reset_bit, serial_port_one_reset_bit,
      serial_port_zero_reset_bit}, 4'hf);
    chk({port_e_bit, port_d_bit, port_c_bit, port_b_bit, port_a_bit}, 5'h1f);
    capability_mask_b <= 32'h0001_0001;
    wr(PRG_OFF_SRST1, 32'hffff_ffff);
    rdc(PRG_OFF_SRST1, 32'h0001_0001);
    chk({timer_one_reset_bit, timer_zero_reset_bit}, 2'h1);
    for (int i = 0; i < 3; i++) wr(PRG_OFF_SRST0 + 12'(4 * i), 32'h0);
    chk({adc_zero_rst, watchdog_reset_bit, timer_zero_reset_bit, serial_port_zero_reset_bit,
      port_e_bit, port_a_bit}, 6'h0);
    rdc(12'h0fc, 32'h0);
    wr(PRG_OFF_DSGATE, 32'hffff_fff2);
    rdc(PRG_OFF_DSGATE, 32'h0000_0012);
    // Run gating rules while auto gating is on but the part is awake
    run_port_gating <= 5'h05;
    auto_clock_gating <= 1'b1;
    acc(3'h0, 2'h2);
    acc(3'h1, 2'h1);
    acc(3'h7, 2'h1);
    deep_sleep <= 1'b1;
    #1;
    chk(port_clk_en, 5'h12);
    acc(3'h4, 2'h2);
    acc(3'h0, 2'h1);
    rdc(PRG_OFF_STATE, 32'h0000_0112);
    auto_clock_gating <= 1'b0;
    #1;
    chk(port_clk_en, 5'h05);
    deep_sleep <= 1'b0;
    wr(PRG_OFF_IRQ_MASK, 32'h0);
    // Faults, reset set and release, deep entry and exit all seen by now
    rdc(PRG_OFF_IRQ_STAT, 32'h1f);
    wr(PRG_OFF_IRQ_STAT, 32'h1f);
    rdc(PRG_OFF_IRQ_STAT, 32'h0);
    acc(3'h1, 2'h1);
    rdc(PRG_OFF_IRQ_STAT, 32'h1);
    chk(irq, 1'b0);
    wr(PRG_OFF_IRQ_MASK, 32'h1);
    chk(irq, 1'b1);
    wr(PRG_OFF_IRQ_STAT, 32'h1);
    chk(irq, 1'b0);
    wr(PRG_OFF_SRST2, 32'h1);
    wr(PRG_OFF_SRST2, 32'h0);
    rdc(PRG_OFF_IRQ_STAT, 32'h6);
    // Second reset in mid-run must clear a held unit
    wr(PRG_OFF_SRST0, 32'hffff_ffff);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdc(PRG_OFF_SRST0, 32'h0);
    print_verdict();
  end
endmodule
